//--- inc/plc_cfg.svh
`ifndef PLC_CFG_SVH
`define PLC_CFG_SVH

// Code words sent in the key/action slot
`define SELECTED_ON_CMD 5'h12
`define SELECTED_OFF_CMD 5'h1A
`define ALL_OFF_CMD 5'h1C
`define LAMPS_ALL_ON_CMD 5'h14
`define DIM_CMD 5'h1E
`define BRIGHT_CMD 5'h16
`define KEY_FLIP 5'h08

// Frame layout: start pattern, then house and key/action, complemented
`define START_CODE 4'hE
`define FRAME_SYMS 22
`define LAST_SYM 5'h15
`define HOUSE_LSB 5

// Repeats and pacing
`define DEFAULT_REPS 8'h02
`define BRIGHT_LEVELS 19
`define GAP_LAST 3'h5

// Timing
`define CLK_MHZ 25
`define BURST_US 1000
`define ZC_PREC_US 50

`endif

//--- inc/plc_pkg.sv
`default_nettype none

package plc_pkg;

    // One entry of a request
    typedef struct packed {
        logic [3:0] house;
        logic [4:0] key_or_action;
        logic has_count;
        logic [7:0] count;
    } entry_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOAD,
        ST_LATCH,
        ST_SEND,
        ST_GAP
    } sender_state_t;

endpackage : plc_pkg

`default_nettype wire

//--- hw/entry_mem.sv
`timescale 1ns/1ps
`default_nettype none

module entry_mem #(
    parameter int AW = 4
) (
    input wire logic core_clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire plc_pkg::entry_t wr_data,
    input wire logic [AW-1:0] rd_addr,
    output plc_pkg::entry_t rd_data
);
    import plc_pkg::*;

    entry_t mem [0:(1<<AW)-1];
    entry_t rd_data_reg;

    // Registered read keeps this a plain RAM for synthesis
    always_ff @(posedge core_clk)
    begin
        if (wr_en)
            mem[wr_addr] <= wr_data;
        rd_data_reg <= mem[rd_addr];
    end

    assign rd_data = rd_data_reg;

endmodule : entry_mem

`default_nettype wire

//--- hw/powerline_command_sender.sv
`timescale 1ns/1ps
`default_nettype none
`include "plc_cfg.svh"

module powerline_command_sender #(
    parameter int AW = 4,
    parameter int BURST_CYCLES = `BURST_US * `CLK_MHZ
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic ent_wr_en,
    input wire logic [AW-1:0] ent_wr_addr,
    input wire plc_pkg::entry_t ent_wr_data,
    input wire logic start,
    input wire logic [AW-1:0] entry_last,
    input wire logic [3:0] mod_pin_sel,
    input wire logic [3:0] zc_pin_sel,
    input wire logic [15:0] gpio_in,
    output logic [15:0] gpio_out,
    output logic [15:0] gpio_oe,
    output logic busy
);
    import plc_pkg::*;

    localparam int BW = $clog2(BURST_CYCLES + 1);
    localparam int ZC_PREC_CYC = `ZC_PREC_US * `CLK_MHZ;
    localparam int ZC_LAT_MAX = 3;

    sender_state_t state_reg;
    sender_state_t state_next;
    logic [AW-1:0] idx_reg;
    logic [AW-1:0] last_reg;
    logic [3:0] mod_sel_reg;
    logic [3:0] zc_sel_reg;
    logic [7:0] rep_reg;
    logic [7:0] rep_next;
    logic [4:0] sym_reg;
    logic [2:0] gap_reg;
    logic [BW-1:0] burst_cnt_reg;
    logic [15:0] sync1_reg;
    logic [15:0] sync2_reg;
    logic zc_prev_reg;
    logic [15:0] gpio_out_reg;
    logic [15:0] gpio_oe_reg;
    logic busy_reg;
    entry_t entry_reg;
    entry_t rd_data;

    // Request acceptance and frame decode
    wire accept = start && !busy_reg;
    wire mem_wr = ent_wr_en && !busy_reg;
    wire zc_level = sync2_reg[zc_sel_reg];
    wire zc_edge = zc_level ^ zc_prev_reg;
    // Action codes pass through untouched, so on/off stay one bit apart
    wire [8:0] payload = {entry_reg.house, entry_reg.key_or_action};
    wire [`FRAME_SYMS-1:0] frame_pat;
    wire [4:0] sym_pos = 5'(`FRAME_SYMS - 1) - sym_reg;
    wire sym_bit = frame_pat[sym_pos];
    wire frame_end = sym_reg == `LAST_SYM;
    wire last_entry = idx_reg == last_reg;
    wire burst_on = burst_cnt_reg != '0;
    wire [15:0] mod_onehot = 16'h0001 << mod_sel_reg;
    wire mod_level = gpio_out_reg[mod_sel_reg];

    // Start pattern stays uncomplemented so it cannot mimic data
    assign frame_pat[`FRAME_SYMS-1:`FRAME_SYMS-4] = `START_CODE;
    genvar j;
    generate
        for (j = 0; j < 9; j++)
        begin : g_sym
            assign frame_pat[2*j+1] = payload[j];
            assign frame_pat[2*j] = ~payload[j];
        end
    endgenerate

    // Missing count falls back to two; zero is taken as one
    assign rep_next = !rd_data.has_count ? `DEFAULT_REPS :
                      (rd_data.count == 8'h00) ? 8'h01 : rd_data.count;

    entry_mem #(
        .AW(AW)
    ) u_entries (
        .core_clk(core_clk),
        .wr_en(mem_wr),
        .wr_addr(ent_wr_addr),
        .wr_data(ent_wr_data),
        .rd_addr(idx_reg),
        .rd_data(rd_data)
    );

    // Sequencer
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: if (accept) state_next = ST_LOAD;
            ST_LOAD: state_next = ST_LATCH;
            ST_LATCH: state_next = ST_SEND;
            ST_SEND:
                if (zc_edge && frame_end && rep_reg == 8'h01)
                    state_next = ST_GAP;
            ST_GAP:
                if (last_entry && !burst_on)
                    state_next = ST_IDLE;
                else if (!last_entry && zc_edge && gap_reg == `GAP_LAST)
                    state_next = ST_LOAD;
        endcase
    end

    // Two-stage synchroniser on all pins; selection after it
    always_ff @(posedge core_clk)
    begin
        sync1_reg <= gpio_in;
        sync2_reg <= sync1_reg;
        zc_prev_reg <= zc_level;
    end

    // Request state
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b0;
            idx_reg <= '0;
            last_reg <= '0;
            mod_sel_reg <= 4'h0;
            zc_sel_reg <= 4'h0;
        end
        else
        begin
            state_reg <= state_next;
            busy_reg <= state_next != ST_IDLE;
            if (accept)
            begin
                idx_reg <= '0;
                last_reg <= entry_last;
                mod_sel_reg <= mod_pin_sel;
                zc_sel_reg <= zc_pin_sel;
            end
            else if (state_reg == ST_GAP && state_next == ST_LOAD)
                idx_reg <= idx_reg + 1'b1;
        end
    end

    // Symbol, repeat and gap counters
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            entry_reg <= '0;
            rep_reg <= 8'h00;
            sym_reg <= 5'h00;
            gap_reg <= 3'h0;
        end
        else if (state_reg == ST_LATCH)
        begin
            entry_reg <= rd_data;
            rep_reg <= rep_next;
            sym_reg <= 5'h00;
            gap_reg <= 3'h0;
        end
        else if (zc_edge && state_reg == ST_SEND)
        begin
            sym_reg <= frame_end ? 5'h00 : sym_reg + 5'h01;
            if (frame_end)
                rep_reg <= rep_reg - 8'h01;
        end
        else if (zc_edge && state_reg == ST_GAP)
            gap_reg <= gap_reg + 3'h1;
    end

    // Carrier burst count loads on the detected crossing edge; the pin rises two clocks later
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
            burst_cnt_reg <= '0;
        else if (zc_edge && state_reg == ST_SEND && sym_bit)
            burst_cnt_reg <= BW'(BURST_CYCLES);
        else if (burst_on)
            burst_cnt_reg <= burst_cnt_reg - 1'b1;
    end

    // Pin drivers; direction held after a request, as a set pin mode
    always_ff @(posedge core_clk)
    begin
        if (!rst_b)
        begin
            gpio_out_reg <= 16'h0000;
            gpio_oe_reg <= 16'h0000;
        end
        else
        begin
            gpio_out_reg <= burst_on ? mod_onehot : 16'h0000;
            if (state_reg == ST_LOAD)
                gpio_oe_reg <= mod_onehot;
        end
    end

    assign gpio_out = gpio_out_reg;
    assign gpio_oe = gpio_oe_reg;
    assign busy = busy_reg;

    // Checks
    mod_is_output_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        busy_reg && state_reg != ST_LOAD |-> gpio_oe_reg == mod_onehot)
        else $error("modulation pin not in output mode");
    zc_is_input_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        busy_reg && zc_sel_reg != mod_sel_reg |-> !gpio_oe_reg[zc_sel_reg])
        else $error("zero-crossing pin driven");
    default_reps_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_reg == ST_LATCH && !rd_data.has_count |=> rep_reg == 8'h02)
        else $error("default repeat count wrong");
    start_pattern_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_reg == ST_SEND && sym_reg < 5'h04
        |-> sym_bit == (sym_reg != 5'h03))
        else $error("start pattern wrong");
    pair_complement_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_reg == ST_SEND && sym_reg > 5'h04 && sym_reg[0]
        |-> sym_bit == !frame_pat[5'(sym_pos + 5'h01)])
        else $error("data symbol not complemented");
    entry_order_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        busy_reg && $past(busy_reg) && idx_reg != $past(idx_reg)
        |-> idx_reg == $past(idx_reg) + 1'b1)
        else $error("entries out of order");
    levels_fit_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_reg == ST_LATCH && rd_data.has_count && rd_data.count != 8'h00
        |=> rep_reg == $past(rd_data.count))
        else $error("repeat count not loaded");
    mod_after_edge_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        zc_edge && state_reg == ST_SEND && sym_bit
        |-> ##[1:ZC_LAT_MAX] mod_level)
        else $error("burst late after crossing");
    mod_on_crossing_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(mod_level) && $stable(mod_sel_reg) |-> $past(zc_edge, 2))
        else $error("burst not started by crossing");
    busy_on_start_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        accept |=> busy_reg ##1 busy_reg)
        else $error("busy missing after start");
    no_restart_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        busy_reg && start |=> $stable(last_reg) && $stable(mod_sel_reg))
        else $error("request taken while busy");

    frame_done_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        state_reg == ST_SEND ##1 state_reg == ST_GAP);
    chain_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        state_reg == ST_GAP ##1 state_reg == ST_LOAD);
    request_done_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        $fell(busy_reg));

endmodule : powerline_command_sender

`default_nettype wire

//--- verif/zc_partner.sv
`timescale 1ns/1ps
`default_nettype none

module zc_partner (
    input wire logic run,
    input wire logic mod,
    output logic zc
);
    realtime edge_t[$];
    int ones[$];
    int n_before;

    // Crossing every 160 ns while running; at rest the line sits at pull-up
    initial
    begin
        zc = 1'b1;
        #7;
        forever
        begin
            #160;
            if (run)
            begin
                zc = ~zc;
                edge_t.push_back($realtime);
            end
            else
                zc = 1'b1;
        end
    end

    // A burst belongs to the last crossing more than 100 ns before it
    always @(posedge mod)
    begin
        n_before = 0;
        foreach (edge_t[i])
            if (edge_t[i] < $realtime - 100.0)
                n_before++;
        ones.push_back(n_before - 1);
    end
endmodule : zc_partner

`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "plc_cfg.svh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
$display("mismatch %s exp %0h got %0h", n, e, g); end end

module tb;
    import plc_pkg::*;
    logic core_clk = 1'b0, rst_b = 1'b0, ent_wr_en = 1'b0, start = 1'b0;
    logic run = 1'b0, busy, zc;
    logic [3:0] ent_wr_addr = 4'h0, entry_last = 4'h0;
    logic [3:0] mod_pin_sel = 4'h1, zc_pin_sel = 4'h0;
    logic [15:0] pin_in, gpio_out, gpio_oe;
    logic [4:0] cmds [6] = '{`SELECTED_ON_CMD, `SELECTED_OFF_CMD,
        `ALL_OFF_CMD, `LAMPS_ALL_ON_CMD, `DIM_CMD, `BRIGHT_CMD};
    entry_t ent_wr_data = '0;
    entry_t req[$];
    int err_count = 0, n_tests = 0, exp_q[$], pos;

    always #20 core_clk = ~core_clk;

    // Unselected pins idle high through their pull-ups
    always_comb
    begin
        pin_in = 16'hFFFF;
        pin_in[zc_pin_sel] = zc;
    end

    powerline_command_sender #(.BURST_CYCLES(2)) uut (
        .core_clk(core_clk), .rst_b(rst_b), .ent_wr_en(ent_wr_en),
        .ent_wr_addr(ent_wr_addr), .ent_wr_data(ent_wr_data),
        .start(start), .entry_last(entry_last), .mod_pin_sel(mod_pin_sel),
        .zc_pin_sel(zc_pin_sel), .gpio_in(pin_in), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .busy(busy)
    );

    zc_partner pm (.run(run), .mod(gpio_out[mod_pin_sel]), .zc(zc));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // Store one entry and note it for the expected stream
    task automatic put(input logic [3:0] a, input entry_t e);
        @(posedge core_clk);
        ent_wr_en <= 1'b1;
        ent_wr_addr <= a;
        ent_wr_data <= e;
        @(posedge core_clk);
        ent_wr_en <= 1'b0;
        req.push_back(e);
    endtask : put

    // Run the noted entries; poke tries a write and a start while busy
    task automatic send(input logic [3:0] mp, zp, input logic poke);
        int reps, k;
        logic [8:0] w;
        pos = 0;
        exp_q.delete();
        pm.ones.delete();
        pm.edge_t.delete();
        foreach (req[i])
        begin
            reps = !req[i].has_count ? 2 : (req[i].count == 0) ? 1
                : int'(req[i].count);
            w = {req[i].house, req[i].key_or_action};
            repeat (reps)
            begin
                for (k = 0; k < 3; k++)
                    exp_q.push_back(pos + k);
                pos += 4;
                for (k = 8; k >= 0; k--)
                begin
                    exp_q.push_back(w[k] ? pos : pos + 1);
                    pos += 2;
                end
            end
            pos += 6;
        end
        @(posedge core_clk);
        mod_pin_sel <= mp;
        zc_pin_sel <= zp;
        entry_last <= 4'(req.size() - 1);
        start <= 1'b1;
        @(posedge core_clk);
        start <= 1'b0;
        @(posedge core_clk);
        `CHK("busy", 1'b1, busy)
        if (poke)
        begin
            ent_wr_en <= 1'b1;
            ent_wr_addr <= entry_last;
            ent_wr_data <= '1;
            start <= 1'b1;
            @(posedge core_clk);
            ent_wr_en <= 1'b0;
            start <= 1'b0;
        end
        run <= 1'b1;
        for (k = 0; k < 40000 && busy === 1'b1; k++)
            @(posedge core_clk);
        run <= 1'b0;
        if (k == 40000)
        begin
            err_count++;
            give_verdict();
        end
        `CHK("bursts", exp_q.size(), pm.ones.size())
        foreach (exp_q[i])
            if (i < pm.ones.size())
                `CHK("symbol", exp_q[i], pm.ones[i])
        repeat (4) @(posedge core_clk);
        `CHK("oe", 16'h0001 << mp, gpio_oe)
        `CHK("out", 16'h0000, gpio_out)
        req.delete();
    endtask : send

    initial
    begin
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge core_clk);
        `CHK("oe", 16'h0000, gpio_oe)
        `CHK("busy", 1'b0, busy)
        // Plain unit key, default repeat count
        put(4'h0, '{4'h5, 5'h03, 1'b0, 8'h00});
        send(4'h1, 4'h0, 1'b0);
        // Key 16 then every action, chained with count two
        put(4'h0, '{4'hA, 5'h0F, 1'b1, 8'h02});
        for (int i = 0; i < 6; i++)
            put(4'(i + 1), '{4'hF, cmds[i], 1'b1, 8'h02});
        send(4'hF, 4'hE, 1'b1);
        // Full dimming run, then a zero count
        put(4'h0, '{4'h3, `DIM_CMD, 1'b1, 8'd`BRIGHT_LEVELS});
        put(4'h1, '{4'h3, `BRIGHT_CMD, 1'b1, 8'h00});
        send(4'h0, 4'h7, 1'b0);
        give_verdict();
    end
endmodule : tb

`default_nettype wire
